// file: hdl/ldc_regs.svh
`ifndef LDC_REGS_SVH
`define LDC_REGS_SVH

// register offsets
`define LDC_OFS_CONTROL 8'h00
`define LDC_OFS_KEYPAD 8'h01
`define LDC_OFS_KEY_LIMIT 8'h02
`define LDC_OFS_BL_CONTROL 8'h03
`define LDC_OFS_PRI_CODE 8'h04
`define LDC_OFS_SEC_CODE 8'h05
`define LDC_OFS_PIN_CONTROL 8'h06
`define LDC_OFS_EXT_GATE 8'h2b

// control register fields
`define LDC_CTL_OUT_A_ON 0
`define LDC_CTL_OUT_B_ON 1
`define LDC_CTL_OUT_C_ON 2
`define LDC_CTL_KEYPAD_EN 3
`define LDC_CTL_INT_PWM 4
`define LDC_CTL_MODE 5
`define LDC_CTL_RESET 8'h20

// keypad register fields
`define LDC_KP_OVERLAP 0
`define LDC_KP_BRIGHT_LSB 1
`define LDC_KP_BALANCE_LSB 4

// limit fields
`define LDC_LIM_A_LSB 4
`define LDC_LIM_B_LSB 2
`define LDC_LIM_C_LSB 0

// backlight control fields
`define LDC_BL_SEC_EN 0
`define LDC_BL_PRI_EN 1
`define LDC_BL_SHARED 2
`define LDC_BL_FADE_EN 3
`define LDC_BL_FADE_SEL 4
`define LDC_BL_SLOPE 5

// pin control and gate select fields
`define LDC_PIN_PWM_EN 4
`define LDC_EG_A 0
`define LDC_EG_B 1
`define LDC_EG_C 2
`define LDC_EG_PRI 3
`define LDC_EG_SEC 4

// timing
`define LDC_CLK_NS 50
`define LDC_FRAME_NS 50000
`define LDC_FRAME_CYC (`LDC_FRAME_NS / `LDC_CLK_NS)
`define LDC_FADE_STEPS 255
`define LDC_FADE_SLOW_NS 1300000000
`define LDC_FADE_FAST_NS 650000000
`define LDC_FADE_SLOW_CYC (`LDC_FADE_SLOW_NS / `LDC_CLK_NS / `LDC_FADE_STEPS)
`define LDC_FADE_FAST_CYC (`LDC_FADE_FAST_NS / `LDC_CLK_NS / `LDC_FADE_STEPS)

`endif

// file: hdl/ldc_pkg.sv
package ldc_pkg;
   typedef logic [7:0] ldc_byte_t;
   typedef logic [7:0] ldc_code_t;
   // slot shares in twelfths of the active window
   typedef struct packed {
      logic [3:0] a;
      logic [3:0] b;
   } ldc_share_t;
   typedef enum logic [1:0] {
      LDC_KP_OFF = 2'b00,
      LDC_KP_DIRECT = 2'b01,
      LDC_KP_PWM = 2'b11
   } ldc_kp_mode_t;
endpackage

// file: hdl/ldc_fade_if.sv
`timescale 1ns/1ps
interface ldc_fade_if;
   logic [7:0] target;
   logic ramp_en;
   logic slope_fast;
   logic [7:0] value;
   modport engine (
      input target,
      input ramp_en,
      input slope_fast,
      output value
   );
   modport user (
      output target,
      output ramp_en,
      output slope_fast,
      input value
   );
endinterface

// file: hdl/ldc_fade.sv
`timescale 1ns/1ps
`include "ldc_regs.svh"
module ldc_fade
   import ldc_pkg::*;
#(
   parameter int SLOW_CYC = `LDC_FADE_SLOW_CYC,
   parameter int FAST_CYC = `LDC_FADE_FAST_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // ramp control
   ldc_fade_if.engine fi
);
   logic [16:0] tick_q;
   logic [16:0] limit;
   ldc_code_t val_q;
   logic step;

   assign limit = fi.slope_fast ? 17'(FAST_CYC - 1) : 17'(SLOW_CYC - 1);
   assign step = (tick_q >= limit);
   assign fi.value = val_q;

   ////////////////////////////////////////////////////////////////////////
   // step interval timer, idle while on target
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tick_q <= 17'h00000;
      end else if (clk_en) begin
         if (!fi.ramp_en || val_q == fi.target || step) begin
            tick_q <= 17'h00000;
         end else begin
            tick_q <= tick_q + 17'h00001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one count per interval toward target
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         val_q <= 8'h00;
      end else if (clk_en) begin
         if (!fi.ramp_en) begin
            val_q <= fi.target;
         end else if (step && val_q < fi.target) begin
            val_q <= val_q + 8'h01;
         end else if (step && val_q > fi.target) begin
            val_q <= val_q - 8'h01;
         end
      end
   end
endmodule

// file: hdl/ldc_top.sv
`timescale 1ns/1ps
`include "ldc_regs.svh"
module ldc_top
   import ldc_pkg::*;
#(
   parameter int FRAME_CYC = `LDC_FRAME_CYC,
   parameter int FADE_SLOW_CYC = `LDC_FADE_SLOW_CYC,
   parameter int FADE_FAST_CYC = `LDC_FADE_FAST_CYC
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // register port from the serial engine
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   output logic [7:0] reg_rdata,
   // external pwm pin level
   input wire logic ext_pwm_in,
   // keypad outputs
   output logic keypad_out_a,
   output logic keypad_out_b,
   output logic keypad_out_c,
   output logic keypad_switch_mode,
   output logic [1:0] out_a_limit,
   output logic [1:0] out_b_limit,
   output logic [1:0] out_c_limit,
   // backlight outputs
   output logic [7:0] primary_dac_code,
   output logic [7:0] secondary_dac_code,
   output logic primary_sink_on,
   output logic secondary_sink_on
);
   ldc_byte_t control_q;
   ldc_byte_t keypad_q;
   ldc_byte_t keypad_current_limit_q;
   ldc_byte_t backlight_control_q;
   ldc_code_t primary_current_code_q;
   ldc_code_t secondary_current_code_q;
   ldc_byte_t pin_control_q;
   ldc_byte_t ext_gate_q;

   logic [9:0] frame_q;
   logic [13:0] win_len;
   logic [13:0] pos12;
   logic [13:0] edge_ab;
   logic [13:0] edge_bc;
   logic [13:0] edge_end;
   logic [2:0] bright;
   ldc_share_t share;
   logic [2:0] sw_bits;
   logic [2:0] wave;
   logic [2:0] ext_sel;
   logic [2:0] key_d;
   logic pin_pwm_en;
   ldc_kp_mode_t kp_mode;
   logic shared;
   logic fade_en;
   logic fade_sel;
   logic pri_gate;
   logic sec_gate;
   logic [7:0] sec_code;

   ldc_fade_if pri_fi ();
   ldc_fade_if sec_fi ();

   ////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         control_q <= `LDC_CTL_RESET;
         keypad_q <= 8'h00;
         keypad_current_limit_q <= 8'h00;
         backlight_control_q <= 8'h00;
         primary_current_code_q <= 8'h00;
         secondary_current_code_q <= 8'h00;
         pin_control_q <= 8'h00;
         ext_gate_q <= 8'h00;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `LDC_OFS_CONTROL: control_q <= reg_wdata & 8'h3f;
            `LDC_OFS_KEYPAD: keypad_q <= reg_wdata & 8'h7f;
            `LDC_OFS_KEY_LIMIT: begin
               keypad_current_limit_q <= reg_wdata & 8'h3f;
            end
            `LDC_OFS_BL_CONTROL: begin
               backlight_control_q <= reg_wdata & 8'h3f;
            end
            `LDC_OFS_PRI_CODE: primary_current_code_q <= reg_wdata;
            `LDC_OFS_SEC_CODE: begin
               secondary_current_code_q <= reg_wdata;
            end
            `LDC_OFS_PIN_CONTROL: pin_control_q <= reg_wdata & 8'h17;
            `LDC_OFS_EXT_GATE: ext_gate_q <= reg_wdata & 8'h1f;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register reads, unmapped reads zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         case (reg_addr)
            `LDC_OFS_CONTROL: reg_rdata <= control_q;
            `LDC_OFS_KEYPAD: reg_rdata <= keypad_q;
            `LDC_OFS_KEY_LIMIT: reg_rdata <= keypad_current_limit_q;
            `LDC_OFS_BL_CONTROL: reg_rdata <= backlight_control_q;
            `LDC_OFS_PRI_CODE: reg_rdata <= primary_current_code_q;
            `LDC_OFS_SEC_CODE: reg_rdata <= secondary_current_code_q;
            `LDC_OFS_PIN_CONTROL: reg_rdata <= pin_control_q;
            `LDC_OFS_EXT_GATE: reg_rdata <= ext_gate_q;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // keypad mode decode
   assign sw_bits = {control_q[`LDC_CTL_OUT_C_ON],
                     control_q[`LDC_CTL_OUT_B_ON],
                     control_q[`LDC_CTL_OUT_A_ON]};
   assign pin_pwm_en = pin_control_q[`LDC_PIN_PWM_EN];
   assign bright = keypad_q[`LDC_KP_BRIGHT_LSB +: 3];

   always_comb begin
      if (!control_q[`LDC_CTL_KEYPAD_EN]) begin
         kp_mode = LDC_KP_OFF;
      end else if (control_q[`LDC_CTL_INT_PWM]) begin
         kp_mode = LDC_KP_PWM;
      end else begin
         kp_mode = LDC_KP_DIRECT;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pwm frame counter, one frame per 50 us
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         frame_q <= 10'h000;
      end else if (clk_en) begin
         if (frame_q == 10'(FRAME_CYC - 1)) begin
            frame_q <= 10'h000;
         end else begin
            frame_q <= frame_q + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // active window: 1/64 doubling to whole frame
   always_comb begin
      if (bright == 3'h0) begin
         win_len = 14'h0000;
      end else begin
         win_len = 14'(FRAME_CYC) >> (3'h7 - bright);
      end
   end

   // balance shares in twelfths
   always_comb begin
      case (keypad_q[`LDC_KP_BALANCE_LSB +: 3])
         3'h0: share = '{a: 4'hc, b: 4'h0};
         3'h1: share = '{a: 4'h0, b: 4'hc};
         3'h2: share = '{a: 4'h0, b: 4'h0};
         3'h3: share = '{a: 4'h6, b: 4'h6};
         3'h4: share = '{a: 4'h0, b: 4'h6};
         3'h5: share = '{a: 4'h6, b: 4'h0};
         3'h6: share = '{a: 4'h4, b: 4'h4};
         3'h7: share = '{a: 4'h6, b: 4'h3};
         default: share = '{a: 4'h0, b: 4'h0};
      endcase
   end

   // slot edges scaled by the window, compared in twelfths
   assign pos12 = 14'(frame_q) * 14'd12;
   assign edge_ab = 14'(share.a) * win_len;
   assign edge_bc = 14'(share.a + share.b) * win_len;
   assign edge_end = 14'd12 * win_len;

   always_comb begin
      if (keypad_q[`LDC_KP_OVERLAP]) begin
         wave = {3{pos12 < edge_end}};
      end else begin
         wave[0] = pos12 < edge_ab;
         wave[1] = (pos12 >= edge_ab) && (pos12 < edge_bc);
         wave[2] = (pos12 >= edge_bc) && (pos12 < edge_end);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output combine with external gating
   assign ext_sel = ext_gate_q[`LDC_EG_C:`LDC_EG_A] & {3{pin_pwm_en}};

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         case (kp_mode)
            LDC_KP_DIRECT: key_d[i] = sw_bits[i] &
                                     (!ext_sel[i] || ext_pwm_in);
            LDC_KP_PWM: key_d[i] = sw_bits[i] & wave[i] &
                                  (!ext_sel[i] || ext_pwm_in);
            default: key_d[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         keypad_out_a <= 1'b0;
         keypad_out_b <= 1'b0;
         keypad_out_c <= 1'b0;
      end else if (clk_en) begin
         keypad_out_a <= key_d[0];
         keypad_out_b <= key_d[1];
         keypad_out_c <= key_d[2];
      end
   end

   // sink mode and per-output limits
   assign keypad_switch_mode = control_q[`LDC_CTL_MODE];
   assign out_a_limit = keypad_current_limit_q[`LDC_LIM_A_LSB +: 2];
   assign out_b_limit = keypad_current_limit_q[`LDC_LIM_B_LSB +: 2];
   assign out_c_limit = keypad_current_limit_q[`LDC_LIM_C_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////
   // backlight fade engines
   assign shared = backlight_control_q[`LDC_BL_SHARED];
   assign fade_en = backlight_control_q[`LDC_BL_FADE_EN];
   assign fade_sel = backlight_control_q[`LDC_BL_FADE_SEL];

   assign pri_fi.target = primary_current_code_q;
   assign pri_fi.ramp_en = fade_en && !fade_sel;
   assign pri_fi.slope_fast = backlight_control_q[`LDC_BL_SLOPE];
   assign sec_fi.target = shared ? primary_current_code_q
                                 : secondary_current_code_q;
   assign sec_fi.ramp_en = fade_en && fade_sel;
   assign sec_fi.slope_fast = backlight_control_q[`LDC_BL_SLOPE];

   ldc_fade #(
      .SLOW_CYC(FADE_SLOW_CYC),
      .FAST_CYC(FADE_FAST_CYC)
   ) u_pri_fade (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .fi(pri_fi)
   );

   ldc_fade #(
      .SLOW_CYC(FADE_SLOW_CYC),
      .FAST_CYC(FADE_FAST_CYC)
   ) u_sec_fade (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .fi(sec_fi)
   );

   // shared with select zero: primary ramp drives both
   assign sec_code = (shared && !fade_sel) ? pri_fi.value : sec_fi.value;

   ////////////////////////////////////////////////////////////////////////
   // backlight sink enables and gating
   assign pri_gate = !(ext_gate_q[`LDC_EG_PRI] && pin_pwm_en) || ext_pwm_in;
   assign sec_gate = !(ext_gate_q[`LDC_EG_SEC] && pin_pwm_en) || ext_pwm_in;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         primary_dac_code <= 8'h00;
         secondary_dac_code <= 8'h00;
         primary_sink_on <= 1'b0;
         secondary_sink_on <= 1'b0;
      end else if (clk_en) begin
         primary_dac_code <= pri_fi.value;
         secondary_dac_code <= sec_code;
         primary_sink_on <= backlight_control_q[`LDC_BL_PRI_EN] &&
                            pri_gate;
         secondary_sink_on <= backlight_control_q[`LDC_BL_SEC_EN] &&
                              sec_gate;
      end
   end
endmodule

// file: sim/ldc_ext_pwm.sv
`timescale 1ns/1ps
module ldc_ext_pwm (
   // clock and pattern select
   input wire logic mclk,
   input wire logic [1:0] pwm_mode,
   // pin level
   output logic ext_pwm_in
);
   logic [1:0] ph_q = 2'd0;
   initial ext_pwm_in = 1'b1;
   // 0 low, 1 high, 2 toggles every third cycle; high means on
   always @(posedge mclk) begin
      ph_q <= (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
      if (pwm_mode != 2'd2) ext_pwm_in <= #1 pwm_mode[0];
      else if (ph_q == 2'd2) ext_pwm_in <= #1 ~ext_pwm_in;
   end
endmodule

// file: sim/ldc_top_assertions.sv
`timescale 1ns/1ps
module ldc_top_assertions #(
   parameter int FRAME_CYC = 1000,
   parameter int FADE_SLOW_CYC = 8,
   parameter int FADE_FAST_CYC = 4
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [7:0] reg_rdata,
   // pins
   input wire logic ext_pwm_in,
   input wire logic keypad_out_a,
   input wire logic keypad_out_b,
   input wire logic keypad_out_c,
   input wire logic keypad_switch_mode,
   input wire logic [1:0] out_a_limit,
   input wire logic [1:0] out_b_limit,
   input wire logic [1:0] out_c_limit,
   input wire logic [7:0] primary_dac_code,
   input wire logic [7:0] secondary_dac_code,
   input wire logic primary_sink_on,
   input wire logic secondary_sink_on
);
   logic [7:0] ctl_q, bl_q, pri_q, sec_q, pin_q, eg_q, rd_exp;
   logic [3:0] quiet_q;
   logic rd_ok;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////
   // shadow copies of written registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         {ctl_q, bl_q, pri_q, sec_q, pin_q, eg_q} <= {8'h20, 40'h0};
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            8'h00: ctl_q <= reg_wdata;
            8'h03: bl_q <= reg_wdata;
            8'h04: pri_q <= reg_wdata;
            8'h05: sec_q <= reg_wdata;
            8'h06: pin_q <= reg_wdata;
            8'h2b: eg_q <= reg_wdata;
            default: ;
         endcase
      end
   end
   // cycles since the last write
   always_ff @(posedge mclk) begin
      if (sys_rst || (clk_en && reg_wr)) quiet_q <= 4'h0;
      else if (clk_en && quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
   end
   always_comb begin
      rd_ok = 1'b1;
      rd_exp = 8'h00;
      case (reg_addr)
         8'h00: rd_exp = ctl_q & 8'h3f;
         8'h01, 8'h02: rd_ok = 1'b0;
         8'h03: rd_exp = bl_q & 8'h3f;
         8'h04: rd_exp = pri_q;
         8'h05: rd_exp = sec_q;
         8'h06: rd_exp = pin_q & 8'h17;
         8'h2b: rd_exp = eg_q & 8'h1f;
         default: rd_exp = 8'h00;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   reset_vals_a: assert property (disable iff (1'b0)
      $past(sys_rst) && $past(clk_en) |-> keypad_switch_mode && !keypad_out_a
      && !primary_sink_on && primary_dac_code == 8'h00)
      else $error("outputs wrong after reset");
   limit_wr_a: assert property (clk_en && reg_wr && reg_addr == 8'h02
      |=> {out_a_limit, out_b_limit, out_c_limit} == $past(reg_wdata[5:0]))
      else $error("limit codes do not follow write");
   mode_wr_a: assert property (clk_en && reg_wr && reg_addr == 8'h00
      |=> keypad_switch_mode == $past(reg_wdata[5]))
      else $error("output mode does not follow write");
   read_back_a: assert property (clk_en && rd_ok
      |=> reg_rdata == $past(rd_exp)) else $error("read data wrong");
   sink_pri_a: assert property (clk_en |=> primary_sink_on ==
      $past(bl_q[1] & (~(eg_q[3] & pin_q[4]) | ext_pwm_in)))
      else $error("primary sink enable wrong");
   sink_sec_a: assert property (clk_en |=> secondary_sink_on ==
      $past(bl_q[0] & (~(eg_q[4] & pin_q[4]) | ext_pwm_in)))
      else $error("secondary sink enable wrong");
   code_follow_a: assert property (quiet_q > 4'd2 && !bl_q[3]
      |-> primary_dac_code == pri_q
      && secondary_dac_code == (bl_q[2] ? pri_q : sec_q))
      else $error("dac code does not follow register");
   fade_gap_a: assert property (quiet_q > 4'd2 && bl_q[3] && !bl_q[4]
      && $changed(primary_dac_code) |=> $stable(primary_dac_code)[*3])
      else $error("fade steps too close");
   fade_unit_a: assert property (bl_q[3] && !bl_q[4] && quiet_q > 4'd2
      |-> primary_dac_code + 8'h01 == $past(primary_dac_code)
      || primary_dac_code == $past(primary_dac_code) + 8'h01
      || $stable(primary_dac_code)) else $error("fade step not one count");
   kp_off_a: assert property (quiet_q > 4'd2 && !ctl_q[3]
      |-> !keypad_out_a && !keypad_out_b && !keypad_out_c)
      else $error("keypad output on while disabled");
   kp_direct_a: assert property (quiet_q > 4'd2 && ctl_q[3] && !ctl_q[4]
      |=> keypad_out_a == $past(ctl_q[0] & (~(eg_q[0] & pin_q[4]) | ext_pwm_in)))
      else $error("direct keypad output wrong");
   cover property (bl_q[3] && $changed(primary_dac_code));
   cover property (ctl_q[3] && eg_q[0] && pin_q[4] && $rose(keypad_out_a));
   cover property (bl_q[2] && secondary_dac_code != 8'h00);
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int FRAME = 120;
   typedef struct {logic [7:0] kp, eg; logic [1:0] pm; int a, b, c, all;}
      ldc_row_t;
   logic mclk, sys_rst, clk_en, reg_wr, ext_pwm_in, keypad_switch_mode;
   logic keypad_out_a, keypad_out_b, keypad_out_c;
   logic primary_sink_on, secondary_sink_on;
   logic [1:0] pwm_mode, out_a_limit, out_b_limit, out_c_limit;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [7:0] primary_dac_code, secondary_dac_code;
   logic [7:0] ra[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
      8'h2b};
   logic [7:0] rm[8] = '{8'h3f, 8'h7f, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'h17,
      8'h1f};
   ldc_row_t rows[12] = '{
      '{8'h0f, 8'h00, 2'd1, 120, 120, 120, 120},
      '{8'h0d, 8'h00, 2'd1, 60, 60, 60, 60},
      '{8'h0e, 8'h00, 2'd1, 120, 0, 0, 0},
      '{8'h1e, 8'h00, 2'd1, 0, 120, 0, 0},
      '{8'h2e, 8'h00, 2'd1, 0, 0, 120, 0},
      '{8'h3e, 8'h00, 2'd1, 60, 60, 0, 0},
      '{8'h4e, 8'h00, 2'd1, 0, 60, 60, 0},
      '{8'h5e, 8'h00, 2'd1, 60, 0, 60, 0},
      '{8'h6e, 8'h00, 2'd1, 40, 40, 40, 0},
      '{8'h7c, 8'h00, 2'd1, 30, 15, 15, 0},
      '{8'h0f, 8'h01, 2'd0, 0, 120, 120, 0},
      '{8'h0f, 8'h01, 2'd2, 60, 120, 120, 60}};
   int n_mismatch = 0;
   int tests_run = 0;
   int ca, cb, cc, call, n;

   ldc_top #(.FRAME_CYC(FRAME), .FADE_SLOW_CYC(8), .FADE_FAST_CYC(4)) dut (
      .mclk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
      .ext_pwm_in, .keypad_out_a, .keypad_out_b, .keypad_out_c,
      .keypad_switch_mode, .out_a_limit, .out_b_limit, .out_c_limit,
      .primary_dac_code, .secondary_dac_code, .primary_sink_on,
      .secondary_sink_on);
   ldc_ext_pwm pwm_src (.mclk, .pwm_mode, .ext_pwm_in);

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      // idle cycle so back-to-back writes never reassign the strobe at once
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      tick(2);
      chk(reg_rdata, exp);
   endtask
   task automatic kp_frame;
      ca = 0;
      cb = 0;
      cc = 0;
      call = 0;
      repeat (FRAME) begin
         tick(1);
         ca += keypad_out_a;
         cb += keypad_out_b;
         cc += keypad_out_c;
         call += keypad_out_a & keypad_out_b & keypad_out_c;
      end
   endtask
   task automatic wait_code(input logic [7:0] v);
      n = 0;
      while (primary_dac_code !== v && n < 2000) begin
         tick(1);
         n++;
      end
      if (n == 2000) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {sys_rst, clk_en, reg_wr, reg_addr, reg_wdata} = {2'b11, 17'h0};
      pwm_mode = 2'd1;
      tick(6);
      sys_rst = 1'b0;
      chk({7'h00, keypad_switch_mode}, 8'h01);
      chk(primary_dac_code | secondary_dac_code, 8'h00);
      rd(8'h00, 8'h20);
      foreach (ra[i]) begin
         wr(ra[i], 8'hff);
         rd(ra[i], rm[i]);
      end
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00);
      sys_rst = 1'b1;
      tick(2);
      sys_rst = 1'b0;
      rd(8'h03, 8'h00);
      foreach (rm[i]) begin
         wr(8'h02, (i % 2) ? 8'h1b : 8'h24);
         chk({2'b00, out_a_limit, out_b_limit, out_c_limit}, reg_wdata);
      end
      wr(8'h00, 8'h0d);
      wr(8'h06, 8'h10);
      wr(8'h01, 8'h0f);
      tick(3);
      chk({4'h0, keypad_switch_mode, keypad_out_a, keypad_out_b,
         keypad_out_c}, 8'h05);
      wr(8'h2b, 8'h04);
      pwm_mode = 2'd0;
      tick(3);
      chk({5'h0, keypad_out_a, keypad_out_b, keypad_out_c}, 8'h04);
      wr(8'h00, 8'h07);
      tick(3);
      chk({5'h0, keypad_out_a, keypad_out_b, keypad_out_c}, 8'h00);
      wr(8'h00, 8'h3f);
      foreach (rows[i]) begin
         wr(8'h2b, rows[i].eg);
         wr(8'h01, rows[i].kp);
         pwm_mode = rows[i].pm;
         tick(FRAME);
         kp_frame();
         chk(8'(ca), 8'(rows[i].a));
         chk(8'(cb), 8'(rows[i].b));
         chk(8'(cc), 8'(rows[i].c));
         chk(8'(call), 8'(rows[i].all));
      end
      wr(8'h2b, 8'h00);
      for (int b = 0; b < 8; b++) begin
         wr(8'h01, 8'(b * 2));
         tick(FRAME);
         kp_frame();
         chk(8'(ca), (b == 0) ? 8'h00 : 8'(FRAME >> (7 - b)));
         chk(8'(cb + cc), 8'h00);
      end
      pwm_mode = 2'd1;
      wr(8'h03, 8'h06);
      wr(8'h04, 8'h50);
      wr(8'h05, 8'h20);
      tick(3);
      chk(secondary_dac_code, 8'h50);
      chk({6'h0, primary_sink_on, secondary_sink_on}, 8'h02);
      wr(8'h03, 8'h03);
      tick(3);
      chk(secondary_dac_code, 8'h20);
      wr(8'h2b, 8'h18);
      pwm_mode = 2'd0;
      tick(3);
      chk({6'h0, primary_sink_on, secondary_sink_on}, 8'h00);
      pwm_mode = 2'd1;
      wr(8'h03, 8'h2b);
      wr(8'h04, 8'h10);
      wait_code(8'h10);
      chk(8'(n > 250 && n < 260), 8'h01);
      wr(8'h03, 8'h0b);
      wr(8'h04, 8'h30);
      wait_code(8'h30);
      chk(8'(n > 250 && n < 260), 8'h01);
      wr(8'h03, 8'h0f);
      wr(8'h04, 8'h40);
      wait_code(8'h40);
      chk(secondary_dac_code, 8'h40);
      stop_test();
   end
endmodule

bind ldc_top ldc_top_assertions #(.FRAME_CYC(FRAME_CYC),
   .FADE_SLOW_CYC(FADE_SLOW_CYC), .FADE_FAST_CYC(FADE_FAST_CYC)) chk_i (
   .mclk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
   .ext_pwm_in, .keypad_out_a, .keypad_out_b, .keypad_out_c,
   .keypad_switch_mode, .out_a_limit, .out_b_limit, .out_c_limit,
   .primary_dac_code, .secondary_dac_code, .primary_sink_on,
   .secondary_sink_on);
